// ### common/eeprom_defines.svh
/*
 constants for the two-wire serial eeprom target: array size, protocol codes, timing.
 assumes a 25 MHz system clock.
*/
`ifndef EEPROM_DEFINES_SVH
`define EEPROM_DEFINES_SVH
`define EE_ADDR_W 13
`define EE_DEPTH 8192
`define EE_PAGE_BITS 5
`define EE_DEV_CODE 4'hA
`define EE_CLK_HZ 25000000
`define EE_TWR_MS 5
`define EE_TWR_CYCLES ((`EE_TWR_MS * (`EE_CLK_HZ / 1000)))
`endif

// ### common/eeprom_pkg.sv
/*
 types for the two-wire serial eeprom target.
 assumes nothing beyond the defines header.
*/
package eeprom_pkg;
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_DEV,
      ST_ADDR_HI,
      ST_ADDR_LO,
      ST_WDATA,
      ST_RDATA,
      ST_RACK
   } phase_t;
endpackage : eeprom_pkg

// ### design/two_wire_serial_eeprom_slave.sv
/*
 target-side logic of a two-wire serial eeprom with an 8192-byte array.
 assumes scl and sda arrive asynchronously; the sda wire is resolved outside from sda_oe_o.
*/
`timescale 1ns/1ps
`include "eeprom_defines.svh"
// How it works
// R1: 8192 bytes, 256 pages of 32
// R2: sda change with scl high is control
// R3: sda fall, scl high is start
// R4: sda rise, scl high is stop
// R5: ack low on ninth clock
// R6: standby at power-up and after stop
// R7: controller recovers with nine clocks then start; the bench model's recover sends a stop after the nine clocks
// R8: device word opens with 1010 code
// R9: strap bits must match, else standby
// R10: last device bit selects read or write
// R11: byte write committed on stop
// R12: busy write ignores all inputs
// R13: page write up to 32 bytes
// R14: write address wraps inside page
// R15: ack only after write finished
// R16: address counter keeps last plus one
// R17: reads wrap over whole array
// R18: current read sends counter byte
// R19: random read uses dummy write first
// R20: controller ack continues sequential read
// R21: write lock pin blocks all writes
// R22: sample on rise, drive on fall
// R23: two address bytes, high first
module two_wire_serial_eeprom_slave
(
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire logic clk_en_i,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic chip_select_strap_2_i,
   input wire logic chip_select_strap_1_i,
   input wire logic chip_select_strap_0_i,
   input wire logic write_lock_i,
   output logic sda_o,
   output logic sda_oe_o,
   output logic busy_o
);
   import eeprom_pkg::*;
   parameter int unsigned TWR_CYCLES = `EE_TWR_CYCLES;

   // R1: array storage
   logic [7:0] mem [0:`EE_DEPTH-1];
   logic [7:0] page_buf [0:(1<<`EE_PAGE_BITS)-1];
   logic [1:0] scl_s;
   logic [1:0] sda_s;
   logic scl_q;
   logic sda_q;
   phase_t phase;
   logic [3:0] bit_cnt;
   logic [7:0] shreg;
   logic [12:0] addr;
   logic [12:0] wbase;
   logic [5:0] wcount;
   logic [31:0] twr_cnt;
   logic [12:0] commit_ptr;
   logic committing;
   logic reading;
   logic ack_phase;
   logic [7:0] rd_byte;
   logic [4:0] shreg_hi;
   logic [1:0] lock_s;
   logic [2:0] strap_s0;
   logic [2:0] strap_s1;

   wire scl_rise = scl_s[1] & ~scl_q;
   wire scl_fall = ~scl_s[1] & scl_q;
   // R2: control only when scl high
   wire start_det = scl_s[1] & scl_q & sda_q & ~sda_s[1];
   wire stop_det = scl_s[1] & scl_q & ~sda_q & sda_s[1];
   wire [7:0] rx_byte = {shreg[6:0], sda_s[1]};
   // R9: synchronised strap pins
   wire [2:0] straps = strap_s1;
   // R21: synchronised lock pin
   wire write_locked = lock_s[1];
   // R14: lower five bits step only
   wire [12:0] page_next = {addr[12:5], 5'(addr[4:0] + 5'h01)};
   // R17: whole-array wrap
   wire [12:0] seq_next = 13'(addr + 13'h0001);
   wire [12:0] commit_addr = {wbase[12:5], 5'(wbase[4:0] + commit_ptr[4:0])};

   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
      begin
         scl_s <= 2'h3;
         sda_s <= 2'h3;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         lock_s <= 2'h3;
         strap_s0 <= 3'h0;
         strap_s1 <= 3'h0;
      end
      else if (clk_en_i)
      begin
         scl_s <= {scl_s[0], scl_i};
         sda_s <= {sda_s[0], sda_i};
         scl_q <= scl_s[1];
         sda_q <= sda_s[1];
         lock_s <= {lock_s[0], write_lock_i};
         strap_s0 <= {chip_select_strap_2_i, chip_select_strap_1_i, chip_select_strap_0_i};
         strap_s1 <= strap_s0;
      end
   end

   // nonvolatile commit: copies the page buffer during the first cycles of the write time
   always_ff @(posedge mclk_i)
   begin
      if (clk_en_i && committing && commit_ptr < 13'(wcount))
         mem[commit_addr] <= page_buf[commit_ptr[4:0]];
   end

   // R18: counter byte staged
   always_ff @(posedge mclk_i)
   begin
      if (clk_en_i)
         rd_byte <= mem[addr];
   end

   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
      begin
         // R6: power-up standby
         phase <= ST_IDLE;
         bit_cnt <= 4'h0;
         shreg <= 8'h00;
         addr <= 13'h0000;
         wbase <= 13'h0000;
         wcount <= 6'h00;
         twr_cnt <= 32'h0;
         commit_ptr <= 13'h0000;
         committing <= 1'b0;
         reading <= 1'b0;
         ack_phase <= 1'b0;
         sda_o <= 1'b0;
         sda_oe_o <= 1'b0;
         busy_o <= 1'b0;
      end
      else if (clk_en_i)
      begin
         if (committing)
         begin
            // R12: inputs ignored while busy
            sda_oe_o <= 1'b0;
            phase <= ST_IDLE;
            commit_ptr <= 13'(commit_ptr + 13'h0001);
            twr_cnt <= 32'(twr_cnt + 32'h1);
            if (twr_cnt + 32'h1 >= TWR_CYCLES)
            begin
               committing <= 1'b0;
               busy_o <= 1'b0;
            end
         end
         else if (stop_det)
         begin
            // R4: stop ends transfer; R11: stop starts commit
            sda_oe_o <= 1'b0;
            phase <= ST_IDLE;
            // R21: lock pin drops the write
            // the stop's own scl rise has already shifted one bit in
            if (phase == ST_WDATA && bit_cnt <= 4'h1 && wcount != 6'h00 && !write_locked)
            begin
               committing <= 1'b1;
               busy_o <= 1'b1;
               twr_cnt <= 32'h0;
               commit_ptr <= 13'h0000;
            end
         end
         else if (start_det)
         begin
            // R3: start, also repeated start
            phase <= ST_DEV;
            bit_cnt <= 4'h0;
            ack_phase <= 1'b0;
            sda_oe_o <= 1'b0;
         end
         else if (phase != ST_IDLE)
         begin
            if (scl_rise)
            begin
               // R22: sample on rising edge
               if (!ack_phase && !(phase == ST_RDATA))
               begin
                  shreg <= rx_byte;
                  bit_cnt <= 4'(bit_cnt + 4'h1);
               end
               else if (ack_phase && phase == ST_RACK)
               begin
                  // R20: master ack continues, nack ends
                  if (sda_s[1])
                     phase <= ST_IDLE;
                  else
                  begin
                     // ack_phase stays set so the coming fall loads the next byte
                     phase <= ST_RDATA;
                     bit_cnt <= 4'h0;
                  end
               end
               else if (phase == ST_RDATA)
                  bit_cnt <= 4'(bit_cnt + 4'h1);
            end
            else if (scl_fall)
            begin
               // R22: drive on falling edge
               if (ack_phase && phase != ST_RACK)
               begin
                  ack_phase <= 1'b0;
                  bit_cnt <= 4'h0;
                  if (phase == ST_RDATA)
                  begin
                     sda_oe_o <= ~rd_byte[7];
                     shreg <= {rd_byte[6:0], 1'b0};
                  end
                  else
                     sda_oe_o <= 1'b0;
               end
               else if (phase == ST_RDATA)
               begin
                  if (bit_cnt == 4'h8)
                  begin
                     sda_oe_o <= 1'b0;
                     phase <= ST_RACK;
                     ack_phase <= 1'b1;
                     // R17: increment with full wrap
                     addr <= seq_next;
                  end
                  else
                  begin
                     sda_oe_o <= ~shreg[7];
                     shreg <= {shreg[6:0], 1'b0};
                  end
               end
               else if (phase == ST_RACK && ack_phase)
               begin
                  sda_oe_o <= ~rd_byte[7];
                  shreg <= {rd_byte[6:0], 1'b0};
               end
               else if (bit_cnt == 4'h8)
               begin
                  // R5: ack on ninth clock
                  ack_phase <= 1'b1;
                  sda_oe_o <= 1'b1;
                  unique case (phase)
                     ST_DEV:
                     begin
                        if (!dev_hit_q(shreg, straps))
                        begin
                           // R9: mismatch returns to standby
                           sda_oe_o <= 1'b0;
                           ack_phase <= 1'b0;
                           phase <= ST_IDLE;
                        end
                        // R10: direction bit
                        else if (shreg[0])
                           phase <= ST_RDATA;
                        else
                           phase <= ST_ADDR_HI;
                     end
                     // R23: high byte first, excess ignored
                     ST_ADDR_HI:
                        phase <= ST_ADDR_LO;
                     ST_ADDR_LO:
                     begin
                        addr <= {shreg_hi, shreg};
                        wbase <= {shreg_hi, shreg};
                        wcount <= 6'h00;
                        phase <= ST_WDATA;
                     end
                     ST_WDATA:
                     begin
                        // R13: page buffer; R14: in-page wrap
                        page_buf[5'(addr[4:0] - wbase[4:0])] <= shreg;
                        if (wcount != 6'h20)
                           wcount <= 6'(wcount + 6'h01);
                        // R16: counter keeps last plus one
                        addr <= page_next;
                     end
                     default:
                        phase <= ST_IDLE;
                  endcase
               end
            end
         end
      end
   end

   always_ff @(posedge mclk_i)
   begin
      if (sys_rst_i)
         shreg_hi <= 5'h00;
      else if (clk_en_i && scl_fall && phase == ST_ADDR_HI && bit_cnt == 4'h8 && !ack_phase)
         shreg_hi <= shreg[4:0];
   end

   // R15: busy suppresses ack; polling sees silence
   function automatic logic dev_hit_q(input logic [7:0] b, input logic [2:0] s);
      dev_hit_q = (b[7:4] == `EE_DEV_CODE) && (b[3:1] == s);
   endfunction : dev_hit_q

endmodule : two_wire_serial_eeprom_slave

// ### sim/bus_ctrl_model.sv
/*
 two-wire bus controller model: drives scl, pulls or releases sda.
 assumes a pull-up resolves sda outside and a 40 ns mclk_i.
*/
`timescale 1ns/1ps
module bus_ctrl_model (
   input wire logic mclk_i,
   input wire logic sda_i,
   output logic scl_o,
   output logic sda_rel_o
);
   initial
   begin
      scl_o = 1'h1;
      sda_rel_o = 1'h1;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask : tick
   task automatic start();
      tick(3);
      sda_rel_o = 1'h1;
      tick(3);
      scl_o = 1'h1;
      tick(4);
      sda_rel_o = 1'h0;
      tick(4);
      scl_o = 1'h0;
   endtask : start
   task automatic bit_io(input logic b, output logic r);
      tick(3);
      sda_rel_o = b;
      tick(3);
      scl_o = 1'h1;
      tick(2);
      r = sda_i;
      scl_o = 1'h0;
   endtask : bit_io
   task automatic xfer(input logic [7:0] d, input logic k, output logic [7:0] q, output logic a);
      for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
      bit_io(k, a);
   endtask : xfer
   task automatic stop();
      tick(3);
      sda_rel_o = 1'h0;
      tick(3);
      scl_o = 1'h1;
      tick(4);
      sda_rel_o = 1'h1;
      tick(8);
   endtask : stop
   task automatic recover();
      logic r;
      scl_o = 1'h0;
      repeat (9) bit_io(1'h1, r);
      stop();
   endtask : recover
endmodule : bus_ctrl_model

// ### sim/eeprom_props.sv
/*
 checker for the eeprom target: sda drive timing and write busy.
 assumes scl_i and sda_i are the resolved bus levels.
*/
`timescale 1ns/1ps
module eeprom_props #(
   parameter int unsigned TWR_CYCLES = 50
) (
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire logic clk_en_i,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe_o,
   input wire logic busy_o
);
   int unsigned busy_len;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);
   always_ff @(posedge mclk_i)
   begin
      // frozen cycles do not count toward the write time
      busy_len <= (sys_rst_i || !busy_o) ? 0 : busy_len + (clk_en_i ? 1 : 0);
   end
   property p_ack_low; sda_o == 1'h0; endproperty
   a_ack_low: assert property (p_ack_low) else $error("sda_o high");
   property p_busy_quiet; busy_o |-> !sda_oe_o; endproperty
   a_busy_quiet: assert property (p_busy_quiet) else $error("drive while busy");
   property p_busy_len; $fell(busy_o) |-> busy_len + 1 >= TWR_CYCLES && busy_len <= TWR_CYCLES + 1; endproperty
   a_busy_len: assert property (p_busy_len) else $error("write time off");
   property p_busy_hold; $rose(busy_o) |-> busy_o [*8]; endproperty
   a_busy_hold: assert property (p_busy_hold) else $error("busy too short");
   property p_commit_stop; $rose(busy_o) |-> scl_i && sda_i; endproperty
   a_commit_stop: assert property (p_commit_stop) else $error("busy without stop");
   property p_drive_fall; $changed(sda_oe_o) |-> $past(scl_i, 5) && !$past(scl_i, 2); endproperty
   a_drive_fall: assert property (p_drive_fall) else $error("drive not after fall");
   property p_drive_low; $rose(sda_oe_o) |-> !scl_i [*2]; endproperty
   a_drive_low: assert property (p_drive_low) else $error("drive late");
   property p_reset_idle; $fell(sys_rst_i) |-> !busy_o && !sda_oe_o; endproperty
   a_reset_idle: assert property (p_reset_idle) else $error("not idle at reset");
   c_busy: cover property ($rose(busy_o));
   c_ack: cover property ($rose(sda_oe_o));
   c_done: cover property ($fell(busy_o));
endmodule : eeprom_props
bind two_wire_serial_eeprom_slave eeprom_props #(.TWR_CYCLES(TWR_CYCLES)) u_props (
   .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i), .scl_i(scl_i), .sda_i(sda_i),
   .sda_o(sda_o), .sda_oe_o(sda_oe_o), .busy_o(busy_o));

// ### sim/two_wire_serial_eeprom_slave_tb_top.sv
/*
 bench for the eeprom target, driven through the controller model.
 assumes a pull-up on sda and a 50-cycle write time.
*/
`timescale 1ns/1ps
module two_wire_serial_eeprom_slave_tb_top;
   typedef struct {logic lk; logic [15:0] wa; logic [7:0] wd; logic [15:0] ra; logic [7:0] ex;} row_t;
   localparam logic [2:0] STRAP = 3'h5;
   row_t rows[4] = '{'{1'h0, 16'h0000, 8'h5A, 16'h0000, 8'h5A},
      '{1'h0, 16'h1FFF, 8'hC3, 16'h1FFF, 8'hC3}, '{1'h0, 16'hE010, 8'h3C, 16'h0010, 8'h3C},
      '{1'h1, 16'h0000, 8'hFF, 16'h0000, 8'h5A}};
   logic mclk_i, sys_rst_i, write_lock_i, scl, sda_rel, sda_o, sda_oe, busy, a, clk_en;
   logic [7:0] q, d;
   int bad_count = 0;
   int total_checks = 0;
   wire sda = sda_rel & ~(sda_oe & ~sda_o);
   bus_ctrl_model ctl (.mclk_i(mclk_i), .sda_i(sda), .scl_o(scl), .sda_rel_o(sda_rel));
   two_wire_serial_eeprom_slave #(.TWR_CYCLES(50)) uut (
      .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en), .scl_i(scl), .sda_i(sda),
      .chip_select_strap_2_i(STRAP[2]), .chip_select_strap_1_i(STRAP[1]),
      .chip_select_strap_0_i(STRAP[0]), .write_lock_i(write_lock_i),
      .sda_o(sda_o), .sda_oe_o(sda_oe), .busy_o(busy));
   initial
   begin
      mclk_i = 1'h0;
      forever #20 mclk_i = ~mclk_i;
   end
   task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
      total_checks++;
      if (s !== e)
      begin
         bad_count++;
         $display("mismatch %s exp %h seen %h", n, e, s);
      end
   endtask : check
   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : stop_test
   task automatic sel(input logic [7:0] w, output logic k);
      ctl.start();
      ctl.xfer(w, 1'h1, q, k);
   endtask : sel
   task automatic wb(input logic [7:0] v);
      ctl.xfer(v, 1'h1, q, a);
      check("ack", {7'h0, a}, 8'h00);
   endtask : wb
   task automatic seta(input logic [15:0] ad);
      a = 1'h1;
      for (int i = 0; i < 30 && a; i++) sel({4'hA, STRAP, 1'h0}, a);
      check("poll", {7'h0, a}, 8'h00);
      wb(ad[15:8]);
      wb(ad[7:0]);
   endtask : seta
   task automatic rd(input logic [15:0] ad);
      seta(ad);
      sel({4'hA, STRAP, 1'h1}, a);
      ctl.xfer(8'hFF, 1'h1, d, a);
      ctl.stop();
   endtask : rd
   initial
   begin
      repeat (40000) @(posedge mclk_i);
      bad_count++;
      stop_test();
   end
   initial
   begin
      sys_rst_i = 1'h1;
      clk_en = 1'h1;
      write_lock_i = 1'h0;
      repeat (12) @(posedge mclk_i);
      #1;
      sys_rst_i = 1'h0;
      @(posedge mclk_i);
      #1;
      check("idle", {6'h0, busy, sda_oe}, 8'h00);
      ctl.recover();
      foreach (rows[i])
      begin
         write_lock_i = rows[i].lk;
         seta(rows[i].wa);
         wb(rows[i].wd);
         ctl.stop();
         rd(rows[i].ra);
         check("row", d, rows[i].ex);
      end
      write_lock_i = 1'h0;
      seta(16'h0040);
      for (int i = 0; i < 34; i++) wb(8'(i));
      ctl.stop();
      // enable low must hold the write timer
      clk_en = 1'h0;
      repeat (100) @(posedge mclk_i);
      #1;
      check("freeze", {7'h0, busy}, 8'h01);
      clk_en = 1'h1;
      sel({4'hA, STRAP, 1'h0}, a);
      check("busy", {7'h0, a}, 8'h01);
      seta(16'h0040);
      sel({4'hA, STRAP, 1'h1}, a);
      for (int i = 0; i < 32; i++)
      begin
         ctl.xfer(8'hFF, i == 31, d, a);
         check("page", d, 8'(i < 2 ? i + 32 : i));
      end
      ctl.stop();
      rd(16'h1FFF);
      check("top", d, 8'hC3);
      sel({4'hA, STRAP, 1'h1}, a);
      ctl.xfer(8'hFF, 1'h1, d, a);
      ctl.stop();
      check("wrap", d, 8'h5A);
      sel({4'hA, 3'h2, 1'h0}, a);
      check("strap", {7'h0, a}, 8'h01);
      sel({4'hB, STRAP, 1'h0}, a);
      check("code", {7'h0, a}, 8'h01);
      ctl.stop();
      // reset in mid-run, while a write is busy
      seta(16'h0060);
      wb(8'h77);
      ctl.stop();
      sys_rst_i = 1'h1;
      repeat (3) @(posedge mclk_i);
      #1;
      sys_rst_i = 1'h0;
      @(posedge mclk_i);
      #1;
      check("reset", {6'h0, busy, sda_oe}, 8'h00);
      sel({4'hA, STRAP, 1'h0}, a);
      check("standby", {7'h0, a}, 8'h00);
      ctl.stop();
      stop_test();
   end
endmodule : two_wire_serial_eeprom_slave_tb_top
